// ---- include/sci_pkg.sv ----
/*
   Constants and state encoding for the SMBus client front end.
   Assumes a single 125 MHz system clock and a synchronous active-high reset.
*/
`default_nettype none
package sci_pkg;
   // client addresses selected by the strap pin, and the alert response address
   localparam logic [6:0] ADDR_STRAP_LOW   = 7'h2f;
   localparam logic [6:0] ADDR_STRAP_FLOAT = 7'h3d;
   localparam logic [6:0] ADDR_STRAP_HIGH  = 7'h2e;
   localparam logic [6:0] ADDR_ALERT_RESP  = 7'h0c;
   // strap sense encoding from the pad
   localparam logic [1:0] STRAP_LOW        = 2'h0;
   localparam logic [1:0] STRAP_FLOAT      = 2'h1;
   localparam logic [1:0] STRAP_HIGH       = 2'h2;
   // strap capture delay, lets the synchroniser fill first
   localparam logic [1:0] STRAP_WAIT       = 2'h3;
   // byte framing
   localparam logic [3:0] BYTE_BITS        = 4'h8;
   // inactivity timeout
   localparam int         CLK_KHZ          = 125000;
   localparam int         TIMEOUT_MS       = 30;
   localparam int         TIMEOUT_CYCLES   = TIMEOUT_MS * CLK_KHZ;

   typedef enum logic [6:0]
   {
      ST_IDLE = 7'h01,
      ST_ADDR = 7'h02,
      ST_ACK  = 7'h04,
      ST_RX   = 7'h08,
      ST_TX   = 7'h10,
      ST_HACK = 7'h20,
      ST_SKIP = 7'h40
   } sci_state_e;
endpackage : sci_pkg
`default_nettype wire

// ---- verilog/sci_line_sync.sv ----
/*
   Two-flop synchroniser with edge detection for asynchronous input lines.
   Assumes inputs come from pins; edges are found on the second and third stages.
*/
`timescale 1ns/1ns
`default_nettype none
module sci_line_sync
#(
   parameter int WIDTH = 2
)
(
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             rst,
   // raw lines
   input  wire logic [WIDTH-1:0] lineIn,
   // synchronised level and edges
   output logic      [WIDTH-1:0] lineLvl,
   output logic      [WIDTH-1:0] lineRise,
   output logic      [WIDTH-1:0] lineFall
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;
   logic [WIDTH-1:0] hist_r;

   // first stage feeds only the second; idle bus lines reset high
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         meta_r <= '1;
         sync_r <= '1;
         hist_r <= '1;
      end
      else
      begin
         meta_r <= lineIn;
         sync_r <= meta_r;
         hist_r <= sync_r;
      end
   end

   // edge decode
   assign lineLvl  = sync_r;
   assign lineRise = sync_r & ~hist_r;
   assign lineFall = ~sync_r & hist_r;
endmodule : sci_line_sync
`default_nettype wire

// ---- verilog/sci_client.sv ----
/*
   SMBus client bit engine: start/stop detection, address match, byte shift,
   acknowledge and inactivity timeout. Presents bytes to local register logic.
   Assumes the data pin is open drain with an external pull-up; the clock pin
   is input only. txData must be valid whenever txTake may pulse.
*/
`timescale 1ns/1ns
`default_nettype none
module sci_client
   import sci_pkg::*;
#(
   parameter int TIMEOUT_LEN = TIMEOUT_CYCLES
)
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // bus pins
   input  wire logic       serialClockPin,
   input  wire logic       serialDataIn,
   output logic            serialDataOut,
   output logic            serialDataOeN,
   // strap and side inputs
   input  wire logic [1:0] addrStrapSense,
   input  wire logic       alertInterruptPinN,
   input  wire logic       timeoutDisableBit,
   // alternate link control
   output logic            altLinkEnable,
   // received bytes
   output logic [7:0]      rxData,
   output logic            rxValid,
   output logic            rxFirst,
   // transmitted bytes
   input  wire logic [7:0] txData,
   output logic            txTake,
   output logic            hostNack,
   // status
   output logic            addrMatch,
   output logic            readMode,
   output logic            busActive,
   output logic            timeoutHit
);
   localparam int TW = $clog2(TIMEOUT_LEN + 1);
   localparam logic [TW-1:0] TO_LAST = TW'(TIMEOUT_LEN - 1);

   sci_state_e  state_r, state_nxt;
   logic [3:0]  bitCnt_r, bitCnt_nxt;
   logic [7:0]  shift_r, shift_nxt;
   logic        drive_r, drive_nxt;
   logic        readDir_r, readDir_nxt;
   logic        ara_r, ara_nxt;
   logic        firstRx_r, firstRx_nxt;
   logic [TW-1:0] idleCnt_r;
   logic [6:0]  ownAddr_r;
   logic [1:0]  strapCnt_r;
   logic        strapDone_r;
   logic        altLink_r;
   logic [7:0]  rxData_r;
   logic        rxValid_r, rxFirst_r, txTake_r, hostNack_r, addrMatch_r, timeoutHit_r;

   logic [1:0]  busLvl, busRise, busFall;
   logic [1:0]  strapLvl;

   // bus lines: bit 1 clock, bit 0 data
   sci_line_sync #(.WIDTH(2)) u_bus_sync
   (
      .mclk     (mclk),
      .rst      (rst),
      .lineIn   ({serialClockPin, serialDataIn}),
      .lineLvl  (busLvl),
      .lineRise (busRise),
      .lineFall (busFall)
   );

   // strap pad sense, only the level is used
   sci_line_sync #(.WIDTH(2)) u_strap_sync
   (
      .mclk     (mclk),
      .rst      (rst),
      .lineIn   (addrStrapSense),
      .lineLvl  (strapLvl),
      .lineRise (),
      .lineFall ()
   );

   // bus event decode
   wire sclLvl    = busLvl[1];
   wire sdaLvl    = busLvl[0];
   wire sclRise   = busRise[1];
   wire sclFall   = busFall[1];
   wire startEv   = busFall[0] & sclLvl;
   wire stopEv    = busRise[0] & sclLvl;
   wire anyEdge   = |busRise | |busFall;
   wire timeoutEv = (state_r != ST_IDLE) & ~timeoutDisableBit
                    & (idleCnt_r == TO_LAST);
   wire byteEnd   = sclFall & (bitCnt_r == BYTE_BITS);
   wire addrHit   = strapDone_r & (shift_r[7:1] == ownAddr_r);
   wire araHit    = ~alertInterruptPinN & shift_r[0]
                    & (shift_r[7:1] == ADDR_ALERT_RESP);
   wire addrDone  = (state_r == ST_ADDR) & byteEnd;
   wire rxDone    = (state_r == ST_RX) & byteEnd;
   wire loadTx    = (state_r == ST_ACK) & sclFall & readDir_r;
   wire [7:0] txSrc = ara_r ? {ownAddr_r, 1'b0} : txData;
   wire [6:0] strapAddr = (strapLvl == STRAP_LOW)   ? ADDR_STRAP_LOW :
                          (strapLvl == STRAP_FLOAT) ? ADDR_STRAP_FLOAT :
                                                      ADDR_STRAP_HIGH;

   // bit engine next state; clock edges are taken as they come, so a
   // host that stretches the low phase only delays the next edge
   always_comb
   begin
      state_nxt   = state_r;
      bitCnt_nxt  = bitCnt_r;
      shift_nxt   = shift_r;
      drive_nxt   = drive_r;
      readDir_nxt = readDir_r;
      ara_nxt     = ara_r;
      firstRx_nxt = firstRx_r;
      if (startEv)
      begin
         state_nxt  = ST_ADDR;
         bitCnt_nxt = 4'h0;
         drive_nxt  = 1'b0;
      end
      else if (stopEv | timeoutEv)
      begin
         state_nxt = ST_IDLE;
         drive_nxt = 1'b0;
      end
      else
      begin
         case (state_r)
            ST_ADDR, ST_RX:
            begin
               if (sclRise)
               begin
                  shift_nxt  = {shift_r[6:0], sdaLvl};
                  bitCnt_nxt = bitCnt_r + 4'h1;
               end
               else if (byteEnd)
               begin
                  if (state_r == ST_RX)
                  begin
                     drive_nxt   = 1'b1;
                     firstRx_nxt = 1'b0;
                     state_nxt   = ST_ACK;
                  end
                  else if (addrHit | araHit)
                  begin
                     drive_nxt   = 1'b1;
                     readDir_nxt = shift_r[0];
                     ara_nxt     = araHit;
                     firstRx_nxt = 1'b1;
                     state_nxt   = ST_ACK;
                  end
                  else
                     state_nxt = ST_SKIP;
               end
            end
            ST_ACK:
            begin
               if (sclFall)
               begin
                  bitCnt_nxt = 4'h0;
                  if (readDir_r)
                  begin
                     shift_nxt = txSrc;
                     drive_nxt = ~txSrc[7];
                     state_nxt = ST_TX;
                  end
                  else
                  begin
                     drive_nxt = 1'b0;
                     state_nxt = ST_RX;
                  end
               end
            end
            ST_TX:
            begin
               if (sclRise)
                  bitCnt_nxt = bitCnt_r + 4'h1;
               else if (byteEnd)
               begin
                  drive_nxt = 1'b0;
                  state_nxt = ST_HACK;
               end
               else if (sclFall)
               begin
                  shift_nxt = {shift_r[6:0], 1'b0};
                  drive_nxt = ~shift_r[6];
               end
            end
            ST_HACK:
            begin
               if (sclRise)
                  state_nxt = sdaLvl ? ST_SKIP : ST_ACK;
            end
            ST_IDLE, ST_SKIP:
               state_nxt = state_r;
            default:
            begin
               state_nxt = ST_IDLE;
               drive_nxt = 1'b0;
            end
         endcase
      end
   end

   // engine registers
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         state_r   <= ST_IDLE;
         bitCnt_r  <= 4'h0;
         shift_r   <= 8'h00;
         drive_r   <= 1'b0;
         readDir_r <= 1'b0;
         ara_r     <= 1'b0;
         firstRx_r <= 1'b0;
      end
      else
      begin
         state_r   <= state_nxt;
         bitCnt_r  <= bitCnt_nxt;
         shift_r   <= shift_nxt;
         drive_r   <= drive_nxt;
         readDir_r <= readDir_nxt;
         ara_r     <= ara_nxt;
         firstRx_r <= firstRx_nxt;
      end
   end

   // inactivity counter: any line edge restarts it
   always_ff @(posedge mclk)
   begin
      if (rst || anyEdge || state_r == ST_IDLE || timeoutEv)
         idleCnt_r <= '0;
      else if (idleCnt_r != TO_LAST)
         idleCnt_r <= idleCnt_r + TW'(1);
   end

   // strap captured once, after the synchroniser has filled
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         strapCnt_r  <= 2'h0;
         strapDone_r <= 1'b0;
         ownAddr_r   <= ADDR_STRAP_FLOAT;
      end
      else if (!strapDone_r)
      begin
         strapCnt_r <= strapCnt_r + 2'h1;
         if (strapCnt_r == STRAP_WAIT)
         begin
            strapDone_r <= 1'b1;
            ownAddr_r   <= strapAddr;
         end
      end
   end

   // alternate link stays off once SMBus has been seen
   always_ff @(posedge mclk)
   begin
      if (rst)
         altLink_r <= 1'b1;
      else if (startEv)
         altLink_r <= 1'b0;
   end

   // user-side event pulses
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         rxData_r     <= 8'h00;
         rxValid_r    <= 1'b0;
         rxFirst_r    <= 1'b0;
         txTake_r     <= 1'b0;
         hostNack_r   <= 1'b0;
         addrMatch_r  <= 1'b0;
         timeoutHit_r <= 1'b0;
      end
      else
      begin
         rxValid_r    <= rxDone & ~startEv & ~stopEv & ~timeoutEv;
         rxFirst_r    <= firstRx_r;
         if (rxDone)
            rxData_r <= shift_r;
         txTake_r     <= loadTx & ~startEv & ~stopEv & ~timeoutEv;
         hostNack_r   <= (state_r == ST_HACK) & sclRise & sdaLvl & ~startEv & ~stopEv
                         & ~timeoutEv;
         addrMatch_r  <= addrDone & (addrHit | araHit) & ~startEv & ~stopEv & ~timeoutEv;
         timeoutHit_r <= timeoutEv & ~startEv & ~stopEv;
      end
   end

   // pin drive: open drain, clock pin is never driven
   assign serialDataOut = 1'b0;
   assign serialDataOeN = ~drive_r;
   assign altLinkEnable = altLink_r;
   assign rxData        = rxData_r;
   assign rxValid       = rxValid_r;
   assign rxFirst       = rxFirst_r;
   assign txTake        = txTake_r;
   assign hostNack      = hostNack_r;
   assign addrMatch     = addrMatch_r;
   assign readMode      = readDir_r;
   assign busActive     = (state_r != ST_IDLE);
   assign timeoutHit    = timeoutHit_r;

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_start_to_addr: assert property (startEv |=> state_r == ST_ADDR && !drive_r)
      else $error("start not followed by address phase");
   a_alt_link_off: assert property (startEv |=> !altLinkEnable [*3])
      else $error("alternate link still enabled after start");
   a_stop_to_idle: assert property (stopEv && !startEv |=> state_r == ST_IDLE)
      else $error("stop did not idle the interface");
   a_reset_release: assert property ((stopEv || timeoutEv) |=> serialDataOeN)
      else $error("data line still driven after interface reset");
   a_dir_capture: assert property (addrDone && addrHit && !startEv && !stopEv && !timeoutEv
                                   |=> readDir_r == $past(shift_r[0]))
      else $error("direction bit not captured");
   a_strap_fixed: assert property (strapDone_r |=> $stable(ownAddr_r))
      else $error("client address changed after capture");
   a_msb_first: assert property (state_r == ST_RX && sclRise && !startEv && !stopEv
                                 |=> shift_r[7:1] == $past(shift_r[6:0]))
      else $error("receive shift not msb first");
   a_rx_ack: assert property (rxDone && !startEv && !stopEv && !timeoutEv
                              |=> !serialDataOeN && state_r == ST_ACK)
      else $error("received byte not acknowledged");
   a_addr_miss: assert property (addrDone && !addrHit && !araHit && !startEv && !stopEv
                                 && !timeoutEv |=> state_r == ST_SKIP)
      else $error("foreign address not ignored");
   a_skip_quiet: assert property (state_r == ST_SKIP |-> serialDataOeN)
      else $error("data driven while ignoring bus");
   // a start in the timeout cycle legally wins, so it is left out here
   a_timeout_idle: assert property (timeoutEv && !startEv && !stopEv
                                    |=> state_r == ST_IDLE && timeoutHit ##1 !timeoutHit)
      else $error("timeout did not idle the interface");
   a_timeout_off: assert property (timeoutDisableBit && busActive && !startEv
                                   && !stopEv |=> busActive)
      else $error("timeout fired while disabled");

   c_write_byte: cover property (rxValid && !rxFirst);
   c_read_nack: cover property (hostNack);
   c_timeout: cover property (timeoutHit);
   c_alert_resp: cover property (loadTx && ara_r);
endmodule : sci_client
`default_nettype wire

// ---- dv/sci_host_model.sv ----
/*
   Behavioural SMBus host that drives the clock pin and releases or pulls the data wire.
   Assumes the bench resolves the open-drain data wire, with its pull-up, and feeds it back.
*/
`timescale 1ns/1ns
`default_nettype none
module sci_host_model
(
   // system clock, used only to place pin changes
   input  wire logic mclk,
   // resolved data wire
   input  wire logic sdaWire,
   // host-driven pins
   output logic      serialClockPin,
   output logic      sdaRel
);
   int stretch = 0; // extra clock-low time in ns; a slow host
   // idle bus: clock stands high, data released
   initial
   begin
      serialClockPin = 1'b1;
      sdaRel         = 1'b1;
   end
   // changes land on falling mclk edges so they never race the sampling edge
   task automatic pin(input logic c, input logic d);
      @(negedge mclk);
      serialClockPin = c;
      sdaRel         = d;
   endtask : pin
   // one bit: data set while clock low, wire sampled mid-high
   task automatic bit_clk(input logic rel, output logic seen);
      #20 pin(1'b0, rel);
      #(40 + stretch) pin(1'b1, rel);
      #28 seen = sdaWire;
      #28 pin(1'b0, rel);
   endtask : bit_clk
   // works from idle and as a repeated start from clock low
   task automatic start_cond();
      if (!serialClockPin)
      begin
         #20 pin(1'b0, 1'b1);
         #40 pin(1'b1, 1'b1);
      end
      #60 pin(1'b1, 1'b0);
      #60 pin(1'b0, 1'b0);
   endtask : start_cond
   task automatic stop_cond();
      #20 pin(1'b0, 1'b0);
      #40 pin(1'b1, 1'b0);
      #60 pin(1'b1, 1'b1);
   endtask : stop_cond
   task automatic send_bits(input logic [7:0] b, input int n);
      logic s;
      for (int i = 7; i > 7 - n; i--)
         bit_clk(b[i], s);
   endtask : send_bits
   // eight bits then a released ninth clock for the client's answer
   task automatic write_byte(input logic [7:0] b, output logic ack);
      logic s;
      send_bits(b, 8);
      bit_clk(1'b1, s);
      ack = ~s;
   endtask : write_byte
   task automatic read_byte(input logic nack, output logic [7:0] b);
      logic s;
      for (int i = 0; i < 8; i++)
      begin
         bit_clk(1'b1, s);
         b = {b[6:0], s};
      end
      bit_clk(nack, s);
   endtask : read_byte
endmodule : sci_host_model
`default_nettype wire

// ---- dv/smbus_client_interface_tb.sv ----
/*
   Self-checking bench for the SMBus client front end, with the host model on the bus.
   Assumes a 2000-cycle timeout parameter and an open-drain data wire with pull-up.
*/
`timescale 1ns/1ns
`default_nettype none
module smbus_client_interface_tb
   import sci_pkg::*;
();
   localparam int TO_LEN = 2000; // short timeout keeps the run brief
   typedef struct packed
   {
      logic [1:0] strap;
      logic [7:0] addr;
      logic       ack;
      logic [9:0] stretch;
   } sci_row_s;
   // strap, address byte, expected ack, host stretch
   sci_row_s   rows[6] = '{'{STRAP_LOW, 8'h5e, 1'b1, 10'h0}, '{STRAP_FLOAT, 8'h7a, 1'b1, 10'h1f4},
                           '{STRAP_HIGH, 8'h5c, 1'b1, 10'h0}, '{2'h3, 8'h5c, 1'b1, 10'h0},
                           '{STRAP_LOW, 8'h5c, 1'b0, 10'h0}, '{STRAP_HIGH, 8'h5e, 1'b0, 10'h0}};
   logic       mclk = 1'b0;
   logic       rst = 1'b1;
   logic       serialClockPin, sdaRel, sdaWire, serialDataOut, serialDataOeN, altLinkEnable;
   logic [1:0] addrStrapSense = STRAP_LOW;
   logic       alertInterruptPinN = 1'b1;
   logic       timeoutDisableBit = 1'b0;
   logic [7:0] rxData, b;
   logic [7:0] txData = 8'ha5;
   logic       rxValid, rxFirst, txTake, hostNack, addrMatch, readMode, busActive, timeoutHit, ack;
   logic [8:0] rxQ[$];
   int         nErrors = 0, testsRun = 0, nMatch = 0, nNack = 0, nTimeout = 0;

   initial
   begin
      forever #4 mclk = ~mclk;
   end
   // open drain: the client only ever pulls low
   assign sdaWire = (serialDataOeN === 1'b0) ? serialDataOut : sdaRel;

   sci_client #(.TIMEOUT_LEN(TO_LEN)) i_dut (.mclk(mclk), .rst(rst),
      .serialClockPin(serialClockPin), .serialDataIn(sdaWire), .serialDataOut(serialDataOut),
      .serialDataOeN(serialDataOeN), .addrStrapSense(addrStrapSense),
      .alertInterruptPinN(alertInterruptPinN), .timeoutDisableBit(timeoutDisableBit),
      .altLinkEnable(altLinkEnable), .rxData(rxData), .rxValid(rxValid), .rxFirst(rxFirst),
      .txData(txData), .txTake(txTake), .hostNack(hostNack), .addrMatch(addrMatch),
      .readMode(readMode), .busActive(busActive), .timeoutHit(timeoutHit));
   sci_host_model i_host (.mclk(mclk), .sdaWire(sdaWire), .serialClockPin(serialClockPin),
      .sdaRel(sdaRel));

   // gather single-cycle pulses mid-cycle, where the registered outputs have settled
   always @(negedge mclk)
   begin
      if (rxValid === 1'b1) rxQ.push_back({rxFirst, rxData});
      if (addrMatch === 1'b1) nMatch++;
      if (hostNack === 1'b1) nNack++;
      if (timeoutHit === 1'b1) nTimeout++;
   end
   // next transmit byte offered once the current one is taken
   always @(negedge mclk)
   begin
      if (txTake === 1'b1) txData <= 8'h3c;
   end

   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      testsRun++;
      if (seen !== exp)
      begin
         nErrors++;
         $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", testsRun, nErrors);
      if (nErrors == 0 && testsRun > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask : wait_cyc
   // strap must be settled before release; it is captured only once
   task automatic do_reset();
      rst = 1'b1;
      wait_cyc(5);
      check(9'(serialDataOeN), 9'h1);
      check(9'(altLinkEnable), 9'h1);
      check({busActive, rxData}, 9'h0);
      rst = 1'b0;
      wait_cyc(12);
      rxQ.delete();
      nMatch = 0;
      nNack = 0;
      nTimeout = 0;
   endtask : do_reset

   // watchdog: far beyond the expected run of about 10k cycles
   initial
   begin
      #400000;
      nErrors++;
      $display("Error at %0t ns: watchdog expired", $time);
      tally_and_finish();
   end

   initial
   begin
      // write byte per row: strap choices, own and foreign addresses
      foreach (rows[i])
      begin
         addrStrapSense = rows[i].strap;
         i_host.stretch = int'(rows[i].stretch);
         do_reset();
         i_host.start_cond();
         i_host.write_byte(rows[i].addr, ack);
         check(9'(altLinkEnable), 9'h0);
         check(9'(ack), 9'(rows[i].ack));
         i_host.write_byte(8'h80, ack);
         check(9'(ack), 9'(rows[i].ack));
         i_host.write_byte(8'h01, ack);
         check(9'(ack), 9'(rows[i].ack));
         i_host.stop_cond();
         wait_cyc(8);
         check({busActive, 7'h0, serialDataOeN}, 9'h1);
         check(9'(nMatch), 9'(rows[i].ack));
         check(9'(rxQ.size()), rows[i].ack ? 9'h2 : 9'h0);
         if (rows[i].ack)
         begin
            check(rxQ[0], 9'h180);
            check(rxQ[1], 9'h001);
         end
      end
      // read: two bytes, host nack, then the client stays off the wire
      addrStrapSense = STRAP_LOW;
      i_host.stretch = 0;
      txData = 8'ha5;
      do_reset();
      i_host.start_cond();
      i_host.write_byte(8'h5f, ack);
      check({ack, 7'h0, readMode}, 9'h101);
      i_host.read_byte(1'b0, b);
      check(9'(b), 9'h0a5);
      i_host.read_byte(1'b1, b);
      check(9'(b), 9'h03c);
      check(9'(nNack), 9'h1);
      i_host.read_byte(1'b1, b);
      check(9'(b), 9'h0ff);
      // alert response only while the alert pin is low, then repeated starts
      alertInterruptPinN = 1'b0;
      i_host.start_cond();
      i_host.write_byte(8'h19, ack);
      check(9'(ack), 9'h1);
      i_host.read_byte(1'b1, b);
      check(9'(b), 9'h05e);
      check(9'(nNack), 9'h2);
      alertInterruptPinN = 1'b1;
      i_host.start_cond();
      i_host.write_byte(8'h19, ack);
      check(9'(ack), 9'h0);
      i_host.start_cond();
      i_host.write_byte(8'h5e, ack);
      check(9'(ack), 9'h1);
      // clock held low during the client's ack: timeout frees the wire
      i_host.start_cond();
      i_host.send_bits(8'h5e, 8);
      wait_cyc(20);
      check(9'(serialDataOeN), 9'h0);
      wait_cyc(TO_LEN + 100);
      check(9'(nTimeout), 9'h1);
      check({busActive, 7'h0, serialDataOeN}, 9'h1);
      i_host.stop_cond();
      // same stall with the timeout switched off
      timeoutDisableBit = 1'b1;
      i_host.start_cond();
      i_host.send_bits(8'h5e, 8);
      wait_cyc(TO_LEN + 100);
      check({busActive, 7'h0, serialDataOeN}, 9'h100);
      check(9'(nTimeout), 9'h1);
      i_host.bit_clk(1'b1, ack);
      i_host.stop_cond();
      wait_cyc(8);
      check(9'(busActive), 9'h0);
      tally_and_finish();
   end
endmodule : smbus_client_interface_tb
`default_nettype wire
